// ==== core/carrier_keyer.sv ====
// carrier_keyer: keys one of two carriers with a data stream
// assumes peripheral signals share CLK_SYS; pins are asynchronous
`timescale 1ns/1ps
`default_nettype none

module carrier_keyer
    import keyer_pkg::*;
(
    input  wire logic       CLK_SYS,
    input  wire logic       RESET,
    input  wire keyer_cfg_t CFG,
    input  wire periph_t    PERIPH,
    input  wire pins_t      PINS,
    output var  logic       KEYED_OUTPUT_PIN,
    output var  logic       KEYED_OUTPUT_STATUS
);

    typedef struct packed {
        pins_t  pin_s1;
        pins_t  pin_s2;
        pins_t  pin_s3;
        pins_t  pin_val;
        phase_t phase;
        logic   out;
    } state_t;

    state_t st_r;
    state_t st_nxt;

    logic data_stream_signal;
    logic upper_carrier_signal;
    logic lower_carrier_signal;
    logic active_carrier;
    logic mixed;

    // data stream source decode
    function automatic logic pick_data(
        input logic [DATA_SEL_W-1:0] sel,
        input periph_t               p,
        input logic                  pin,
        input logic                  swb
    );
        logic v;
        v = 1'b0;
        if (sel == DSEL_PIN) begin
            v = pin;
        end else if (sel == DSEL_SWBIT) begin
            v = swb;
        end else if (sel < DSEL_PWM6) begin
            v = p.ccp[3'(sel - DSEL_CCP1)];
        end else if (sel < DSEL_NCO) begin
            v = p.pwm[1'(sel - DSEL_PWM6)];
        end else if (sel == DSEL_NCO) begin
            v = p.nco;
        end else if (sel < DSEL_CLC1) begin
            v = p.cmp[1'(sel - DSEL_CMP1)];
        end else if (sel < DSEL_UDT) begin
            v = p.clc[2'(sel - DSEL_CLC1)];
        end else if (sel == DSEL_UDT) begin
            v = p.uart_dt;
        end else if (sel == DSEL_UTXCK) begin
            v = p.uart_txck;
        end else if (sel <= DSEL_LAST) begin
            v = p.sdo[1'(sel - DSEL_SDO1)];
        end else begin
            v = 1'b0;
        end
        return v;
    endfunction : pick_data

    // carrier source decode, used for both carriers
    function automatic logic pick_carrier(
        input logic [CAR_SEL_W-1:0] sel,
        input periph_t              p,
        input logic                 pin
    );
        logic v;
        v = 1'b0;
        if (sel == CSEL_PIN) begin
            v = pin;
        end else if (sel == CSEL_FOSC) begin
            v = p.fosc;
        end else if (sel == CSEL_HFINT) begin
            v = p.hfint;
        end else if (sel == CSEL_REFCLK) begin
            v = p.refclk;
        end else if (sel < CSEL_PWM6) begin
            v = p.ccp[3'(sel - CSEL_CCP1)];
        end else if (sel < CSEL_NCO) begin
            v = p.pwm[1'(sel - CSEL_PWM6)];
        end else if (sel == CSEL_NCO) begin
            v = p.nco;
        end else begin
            v = p.clc[2'(sel - CSEL_CLC1)];
        end
        return v;
    endfunction : pick_carrier

    // source selection; cfg fields are only read, never changed
    always_comb begin
        if (CFG.enable) begin
            data_stream_signal = pick_data(CFG.data_sel, PERIPH,
                st_r.pin_val.data, CFG.sw_bit);
            upper_carrier_signal = pick_carrier(CFG.upper_sel, PERIPH,
                st_r.pin_val.upper) ^ CFG.upper_invert;
            lower_carrier_signal = pick_carrier(CFG.lower_sel, PERIPH,
                st_r.pin_val.lower) ^ CFG.lower_invert;
        end else begin
            data_stream_signal   = CFG.sw_bit;
            upper_carrier_signal = 1'b0;
            lower_carrier_signal = 1'b0;
        end
    end

    // mixer: the phase follows the data stream, held back by sync
    always_comb begin
        if (st_r.phase == PHASE_UPPER) begin
            active_carrier = upper_carrier_signal;
            mixed = upper_carrier_signal
                & (data_stream_signal | CFG.upper_sync);
        end else begin
            active_carrier = lower_carrier_signal;
            mixed = lower_carrier_signal
                & (~data_stream_signal | CFG.lower_sync);
        end
    end

    // next state
    always_comb begin
        st_nxt        = st_r;
        st_nxt.pin_s1 = PINS;
        st_nxt.pin_s2 = st_r.pin_s1;
        st_nxt.pin_s3 = st_r.pin_s2;
        // a pin change counts once stages two and three agree
        if (st_r.pin_s2.data == st_r.pin_s3.data) begin
            st_nxt.pin_val.data = st_r.pin_s3.data;
        end
        if (st_r.pin_s2.upper == st_r.pin_s3.upper) begin
            st_nxt.pin_val.upper = st_r.pin_s3.upper;
        end
        if (st_r.pin_s2.lower == st_r.pin_s3.lower) begin
            st_nxt.pin_val.lower = st_r.pin_s3.lower;
        end
        // carrier phase; a sync'd switch waits for the carrier to be low
        case (st_r.phase)
            PHASE_UPPER: begin
                if (!data_stream_signal
                    && (!CFG.upper_sync || !upper_carrier_signal)) begin
                    st_nxt.phase = PHASE_LOWER;
                end
            end
            PHASE_LOWER: begin
                if (data_stream_signal
                    && (!CFG.lower_sync || !lower_carrier_signal)) begin
                    st_nxt.phase = PHASE_UPPER;
                end
            end
            default: begin
                st_nxt.phase = PHASE_LOWER;
            end
        endcase
        // output stage: low while disabled, else polarity applied
        if (CFG.enable) begin
            st_nxt.out = mixed ^ CFG.out_invert;
        end else begin
            st_nxt.out = RST_OUT;
        end
    end

    // state register
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            st_r.pin_s1  <= RST_PINS;
            st_r.pin_s2  <= RST_PINS;
            st_r.pin_s3  <= RST_PINS;
            st_r.pin_val <= RST_PINS;
            st_r.phase   <= PHASE_LOWER;
            st_r.out     <= RST_OUT;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign KEYED_OUTPUT_PIN    = st_r.out;
    assign KEYED_OUTPUT_STATUS = st_r.out;

    // checks on the keyer's own logic
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RESET);

    off_output_low_a: assert property (
        !CFG.enable |=> !KEYED_OUTPUT_PIN [*1]
    ) else $error("output not low while disabled");

    mix_value_a: assert property (
        CFG.enable && !CFG.out_invert
        |=> KEYED_OUTPUT_PIN == $past(mixed)
    ) else $error("output does not follow mixer");

    upper_phase_carrier_a: assert property (
        st_r.phase == PHASE_UPPER && data_stream_signal
        |-> active_carrier == upper_carrier_signal
            && mixed == upper_carrier_signal
    ) else $error("upper phase not using upper carrier");

    ground_carriers_a: assert property (
        !CFG.enable
        |-> !upper_carrier_signal && !lower_carrier_signal
    ) else $error("carriers not grounded while disabled");

    soft_data_a: assert property (
        !CFG.enable |-> data_stream_signal == CFG.sw_bit
    ) else $error("data stream not software bit when off");

    select_swbit_a: assert property (
        CFG.enable && CFG.data_sel == DSEL_SWBIT
        |-> data_stream_signal == CFG.sw_bit
    ) else $error("enabled selection not applied");

    invert_out_a: assert property (
        CFG.enable && CFG.out_invert
        |=> KEYED_OUTPUT_PIN == !$past(mixed)
    ) else $error("inverted output wrong");

    sync_hold_a: assert property (
        st_r.phase == PHASE_UPPER && CFG.upper_sync
        && upper_carrier_signal
        |=> st_r.phase == PHASE_UPPER
    ) else $error("switched away before carrier fell");

    nosync_switch_a: assert property (
        st_r.phase == PHASE_LOWER && !CFG.lower_sync
        && data_stream_signal
        |=> st_r.phase == PHASE_UPPER
    ) else $error("phase did not follow data stream");

    unused_code_a: assert property (
        CFG.enable && CFG.data_sel > DSEL_LAST
        |-> !data_stream_signal
    ) else $error("unused data code not zero");

    pin_filter_a: assert property (
        $stable(PINS.data) [*5] |-> st_r.pin_val.data == $past(PINS.data, 4)
    ) else $error("data pin not filtered through");

endmodule : carrier_keyer

`default_nettype wire

// ==== core/keyer_pkg.sv ====
// keyer_pkg: codes, widths, reset values and types of the keyer
// assumes one system clock and a synchronous active high reset
package keyer_pkg;

    localparam int DATA_SEL_W = 5;
    localparam int CAR_SEL_W  = 4;
    localparam int PIN_STAGES = 3;

    // data stream source codes
    localparam logic [4:0] DSEL_PIN    = 5'h00;
    localparam logic [4:0] DSEL_SWBIT  = 5'h01;
    localparam logic [4:0] DSEL_CCP1   = 5'h02;
    localparam logic [4:0] DSEL_PWM6   = 5'h07;
    localparam logic [4:0] DSEL_NCO    = 5'h09;
    localparam logic [4:0] DSEL_CMP1   = 5'h0a;
    localparam logic [4:0] DSEL_CLC1   = 5'h0c;
    localparam logic [4:0] DSEL_UDT    = 5'h10;
    localparam logic [4:0] DSEL_UTXCK  = 5'h11;
    localparam logic [4:0] DSEL_SDO1   = 5'h12;
    localparam logic [4:0] DSEL_LAST   = 5'h13;

    // carrier source codes
    localparam logic [3:0] CSEL_PIN    = 4'h0;
    localparam logic [3:0] CSEL_FOSC   = 4'h1;
    localparam logic [3:0] CSEL_HFINT  = 4'h2;
    localparam logic [3:0] CSEL_REFCLK = 4'h3;
    localparam logic [3:0] CSEL_CCP1   = 4'h4;
    localparam logic [3:0] CSEL_PWM6   = 4'h9;
    localparam logic [3:0] CSEL_NCO    = 4'hb;
    localparam logic [3:0] CSEL_CLC1   = 4'hc;

    // values after reset
    localparam logic       RST_OUT     = 1'b0;
    localparam logic [2:0] RST_PINS    = 3'h0;

    typedef enum logic {PHASE_LOWER, PHASE_UPPER} phase_t;

    typedef struct packed {
        logic                  enable;
        logic                  sw_bit;
        logic                  out_invert;
        logic [DATA_SEL_W-1:0] data_sel;
        logic [CAR_SEL_W-1:0]  upper_sel;
        logic [CAR_SEL_W-1:0]  lower_sel;
        logic                  upper_sync;
        logic                  lower_sync;
        logic                  upper_invert;
        logic                  lower_invert;
    } keyer_cfg_t;

    typedef struct packed {
        logic [4:0] ccp;
        logic [1:0] pwm;
        logic       nco;
        logic [1:0] cmp;
        logic [3:0] clc;
        logic       uart_dt;
        logic       uart_txck;
        logic [1:0] sdo;
        logic       fosc;
        logic       hfint;
        logic       refclk;
    } periph_t;

    // pin triple: data, upper carrier, lower carrier
    typedef struct packed {
        logic data;
        logic upper;
        logic lower;
    } pins_t;

endpackage : keyer_pkg

// ==== verification/carrier_keyer_tb_top.sv ====
// carrier_keyer_tb_top: self-checking bench for the carrier keyer
// assumes keyer_pkg, carrier_keyer and keyer_src_model are compiled first
`timescale 1ns/1ps
`default_nettype none

module carrier_keyer_tb_top
    import keyer_pkg::*;
;
    logic       clk_sys;
    logic       reset;
    keyer_cfg_t cfg;
    periph_t    lvl;
    pins_t      pin_lvl;
    periph_t    periph;
    pins_t      pins;
    logic       out_pin;
    logic       out_stat;
    int         error_cnt;
    int         checks;

    carrier_keyer dut (
        .CLK_SYS             (clk_sys),
        .RESET               (reset),
        .CFG                 (cfg),
        .PERIPH              (periph),
        .PINS                (pins),
        .KEYED_OUTPUT_PIN    (out_pin),
        .KEYED_OUTPUT_STATUS (out_stat)
    );

    keyer_src_model src (
        .lvl     (lvl),
        .pin_lvl (pin_lvl),
        .periph  (periph),
        .pins    (pins)
    );

    // 20 MHz system clock
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    task automatic check(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t ns keyed output %b, wanted %b",
                $time, got, exp);
        end
    endtask : check

    // wait n falling edges, then compare both output views
    task automatic look(input int n, input logic exp);
        repeat (n) @(negedge clk_sys);
        check(out_pin, exp);
        check(out_stat, exp);
    endtask : look

    // one data source at level v; unused codes drive every source
    task automatic set_dat(input int c, input logic v);
        logic [17:0] d;
        d = (c > 19) ? {18{v}} : 18'h0;
        if (c >= 2 && c <= 19) begin
            d[c-2] = v;
        end
        {lvl.sdo, lvl.uart_txck, lvl.uart_dt, lvl.clc} = d[17:10];
        {lvl.cmp, lvl.nco, lvl.pwm, lvl.ccp} = d[9:0];
        pin_lvl.data = (c == 0 || c > 19) ? v : 1'b0;
        cfg.sw_bit = (c == 1 || c > 19) ? v : 1'b0;
    endtask : set_dat

    // one carrier source at level v, all others low
    task automatic set_car(input int c, input logic v);
        logic [15:0] w;
        w = 16'h0;
        w[c] = v;
        {pin_lvl.upper, pin_lvl.lower} = {w[0], w[0]};
        {lvl.refclk, lvl.hfint, lvl.fosc} = w[3:1];
        {lvl.clc, lvl.nco, lvl.pwm, lvl.ccp} = w[15:4];
    endtask : set_car

    // every data code, pins included, carriers fixed high and low
    task automatic scan_data;
        cfg.enable = 1'b1;
        cfg.upper_sel = CSEL_REFCLK;
        cfg.lower_sel = CSEL_HFINT;
        lvl.refclk = 1'b1;
        for (int c = 0; c < 32; c++) begin
            cfg.data_sel = c[4:0];
            set_dat(c, 1'b1);
            look(8, c < 20);
            set_dat(c, 1'b0);
            look(8, 1'b0);
        end
    endtask : scan_data

    // every carrier code on both carriers, data from the software bit
    task automatic scan_car;
        cfg.data_sel = DSEL_SWBIT;
        for (int c = 0; c < 16; c++) begin
            for (int b = 0; b < 2; b++) begin
                cfg.upper_sel = c[3:0];
                cfg.lower_sel = c[3:0];
                set_car(c, 1'b1);
                cfg.sw_bit = b[0];
                look(8, 1'b1);
                set_car(c, 1'b0);
                look(8, 1'b0);
            end
        end
    endtask : scan_car

    // disable forces a low pin whatever the polarity, enable restores
    task automatic enable_case;
        lvl = '0;
        pin_lvl = '0;
        cfg.upper_sel = CSEL_REFCLK;
        cfg.lower_sel = CSEL_HFINT;
        lvl.refclk = 1'b1;
        cfg.data_sel = DSEL_CCP1;
        set_dat(2, 1'b1);
        look(3, 1'b1);
        cfg.enable = 1'b0;
        cfg.sw_bit = 1'b1;
        cfg.out_invert = 1'b1;
        cfg.lower_invert = 1'b1;
        look(1, 1'b0);
        look(4, 1'b0);
        cfg.out_invert = 1'b0;
        cfg.lower_invert = 1'b0;
        cfg.enable = 1'b1;
        cfg.sw_bit = 1'b0;
        look(3, 1'b1);
        set_dat(2, 1'b0);
        look(3, 1'b0);
        cfg.out_invert = 1'b1;
        look(3, 1'b1);
        cfg.out_invert = 1'b0;
    endtask : enable_case

    // upper sync holds the upper carrier until it falls
    task automatic sync_case;
        cfg.upper_sync = 1'b1;
        set_dat(2, 1'b1);
        look(3, 1'b1);
        set_dat(2, 1'b0);
        look(4, 1'b1);
        lvl.refclk = 1'b0;
        look(3, 1'b0);
        lvl.hfint = 1'b1;
        look(3, 1'b1);
        lvl = '0;
        lvl.refclk = 1'b1;
        cfg.upper_sync = 1'b0;
        set_dat(2, 1'b1);
        look(3, 1'b1);
        set_dat(2, 1'b0);
        look(3, 1'b0);
        set_dat(2, 1'b1);
        look(3, 1'b1);
        reset = 1'b1;
        look(2, RST_OUT);
        reset = 1'b0;
        look(3, 1'b1);
    endtask : sync_case

    // carrier polarity and lower sync, each seen at the pin
    task automatic lower_case;
        cfg.upper_invert = 1'b1;
        look(3, 1'b0);
        cfg.upper_invert = 1'b0;
        cfg.lower_sync = 1'b1;
        lvl.refclk = 1'b0;
        lvl.hfint = 1'b1;
        set_dat(2, 1'b0);
        look(3, 1'b1);
        set_dat(2, 1'b1);
        look(4, 1'b1);
        lvl.hfint = 1'b0;
        look(3, 1'b0);
        lvl.refclk = 1'b1;
        look(3, 1'b1);
        cfg.lower_invert = 1'b1;
        set_dat(2, 1'b0);
        look(3, 1'b1);
        cfg.lower_sync = 1'b0;
        cfg.lower_invert = 1'b0;
    endtask : lower_case

    task automatic complete_run;
        if (error_cnt == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : complete_run

    // whole run is about 1100 cycles; cut it at 3000
    initial begin
        #(50 * 3000);
        error_cnt++;
        complete_run();
    end

    // main sequence
    initial begin
        error_cnt = 0;
        checks = 0;
        reset = 1'b1;
        cfg = '0;
        lvl = '0;
        pin_lvl = '0;
        look(10, RST_OUT);
        reset = 1'b0;
        scan_data();
        scan_car();
        enable_case();
        sync_case();
        lower_case();
        complete_run();
    end
endmodule : carrier_keyer_tb_top

`default_nettype wire

// ==== verification/keyer_src_model.sv ====
// keyer_src_model: on-chip peripheral outputs and routed pins for the keyer
// assumes the bench sets the levels just after a falling clock edge
`timescale 1ns/1ps
`default_nettype none

module keyer_src_model
    import keyer_pkg::*;
(
    input  wire periph_t lvl,
    input  wire pins_t   pin_lvl,
    output var  periph_t periph,
    output var  pins_t   pins
);
    // every source is a peripheral output or a routed pin
    always_comb begin
        periph = lvl;
        pins   = pin_lvl;
    end
endmodule : keyer_src_model

`default_nettype wire
